// file: rtl/daq_regs_pkg.sv
// constants and carrier types for the acquisition register group
package daq_regs_pkg;
   localparam logic [4:0] OFS_GAIN_LOW   = 5'h04;
   localparam logic [4:0] OFS_GAIN_HIGH  = 5'h06;
   localparam logic [4:0] OFS_GAIN_RESET = 5'h07;
   localparam logic [4:0] OFS_DAC0       = 5'h08;
   localparam logic [4:0] OFS_STATUS     = 5'h08;
   localparam logic [4:0] OFS_DIAG       = 5'h09;
   localparam logic [4:0] OFS_EEPROM     = 5'h0a;
   localparam logic [4:0] OFS_DAC1       = 5'h0e;
   localparam logic [15:0] DAC_SIMUL_STROBE = 16'h8000;
   localparam int DAC_BITS        = 12;
   localparam int GAIN_CHANNELS   = 16;
   localparam int EE_DATA_BIT     = 7;
   localparam int EE_CLOCK_BIT    = 0;
   localparam int STAT_EMPTY_BIT  = 7;
   localparam int STAT_FULL_BIT   = 6;
   localparam int STAT_HALF_BIT   = 5;
   localparam int DIAG_UNDER_BIT  = 1;
   localparam int DIAG_OVER_BIT   = 0;
   localparam logic [31:0] GAIN_RESET_VALUE = 32'h0000_0000;
   localparam logic [11:0] DAC_RESET_VALUE  = 12'h000;

   typedef enum logic [0:0] {
      DAC_AUTOMATIC    = 1'b0,
      DAC_SIMULTANEOUS = 1'b1
   } dac_mode_t;

   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [4:0]  addr;
      logic [15:0] wdata;
   } host_req_t;

   typedef struct packed {
      logic fifo_empty;
      logic fifo_full;
      logic fifo_over_half;
      logic fifo_empty_read;
   } fifo_state_t;

   typedef struct packed {
      logic dac_a_low_range_jumper;
      logic dac_b_low_range_jumper;
      logic high_gain_jumper;
      logic bipolar_jumper;
      logic sixteen_single_ended;
   } jumpers_t;
endpackage

// file: rtl/pin_sync.sv
// two-stage synchroniser for a group of pin levels
module pin_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk_i,
   input  wire logic             rst_b_i,
   input  wire logic [WIDTH-1:0] d_i,
   output logic      [WIDTH-1:0] q_o
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
   } sync_state_t;
   sync_state_t st;
   sync_state_t next_st;

   initial begin
      if (WIDTH < 1) $error("pin_sync width below one");
   end

   always_comb begin
      next_st.s1 = d_i;
      next_st.s2 = st.s1;
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign q_o = st.s2;
endmodule

// file: rtl/gain_select.sv
// per-channel gain code store and channel lookup
module gain_select
   import daq_regs_pkg::*;
#(
   parameter int CHANNELS = 16
) (
   input  wire logic                        clk_i,
   input  wire logic                        rst_b_i,
   input  wire logic                        wr_low_i,
   input  wire logic                        wr_high_i,
   input  wire logic                        clear_i,
   input  wire logic [15:0]                 wdata_i,
   input  wire logic [$clog2(CHANNELS)-1:0] channel_i,
   output logic      [1:0]                  gain_o
);
   typedef struct packed {
      logic [2*CHANNELS-1:0] codes;
      logic [1:0]            gain;
   } gain_state_t;
   gain_state_t st;
   gain_state_t next_st;

   initial begin
      if (CHANNELS != GAIN_CHANNELS) $error("gain_select needs sixteen channels");
   end

   always_comb begin
      next_st = st;
      if (wr_low_i) next_st.codes[15:0] = wdata_i;
      if (wr_high_i) next_st.codes[31:16] = wdata_i;
      if (clear_i) next_st.codes = GAIN_RESET_VALUE;
      next_st.gain = st.codes[2*channel_i +: 2];
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign gain_o = st.gain;

   gain_clear_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      clear_i |=> st.codes == '0) else $error("gain codes not cleared");
   gain_follow_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      1'b1 |=> gain_o == $past(st.codes[2*channel_i +: 2]))
      else $error("gain does not follow channel");
   gain_low_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      wr_low_i && !clear_i |=> st.codes[15:0] == $past(wdata_i))
      else $error("low gain word not stored");
   gain_high_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      wr_high_i && !clear_i |=> st.codes[31:16] == $past(wdata_i))
      else $error("high gain word not stored");
endmodule

// file: rtl/daq_regs.sv
// host register group: gains, DACs, status and EEPROM port
module daq_regs
   import daq_regs_pkg::*;
(
   input  wire logic                    MCLK_I,
   input  wire logic                    RST_B_I,
   input  wire daq_regs_pkg::host_req_t HOST_REQ_I,
   output logic      [15:0]             HOST_RDATA_O,
   input  wire daq_regs_pkg::fifo_state_t FIFO_I,
   input  wire daq_regs_pkg::jumpers_t  JUMPERS_I,
   input  wire logic                    IRQ_ENABLE_I,
   input  wire daq_regs_pkg::dac_mode_t DAC_MODE_I,
   input  wire logic [3:0]              CHANNEL_I,
   output logic      [1:0]              GAIN_SELECT_O,
   output logic      [11:0]             DAC0_CODE_O,
   output logic      [11:0]             DAC1_CODE_O,
   output logic                         IRQ_O,
   output logic                         EEPROM_DATA_O,
   output logic                         EEPROM_SERIAL_CLOCK_O,
   input  wire logic                    EEPROM_SERIAL_OUT_I
);
   import daq_regs_pkg::*;

   // ======================================================
   // state
   typedef struct packed {
      logic [11:0] dac0_hold;
      logic [11:0] dac1_hold;
      logic [11:0] dac0;
      logic [11:0] dac1;
      logic        overflow_sticky_flag;
      logic        underflow_sticky_flag;
      logic        ee_data;
      logic        ee_clock;
      logic        irq;
      logic [15:0] rdata;
   } regs_state_t;
   regs_state_t st;
   regs_state_t next_st;

   logic [4:0] jumpers_s;
   logic       ee_out_s;
   logic       wr_gain_low;
   logic       wr_gain_high;
   logic       gain_clear;

   function automatic logic hit(input host_req_t r, input logic [4:0] ofs);
      hit = r.addr == ofs;
   endfunction

   // ======================================================
   // pin synchronisers
   pin_sync #(.WIDTH(6)) u_pin_sync (
      .clk_i   (MCLK_I),
      .rst_b_i (RST_B_I),
      .d_i     ({JUMPERS_I, EEPROM_SERIAL_OUT_I}),
      .q_o     ({jumpers_s, ee_out_s})
   );

   // ======================================================
   // gain store
   assign wr_gain_low  = HOST_REQ_I.wr && hit(HOST_REQ_I, OFS_GAIN_LOW);
   assign wr_gain_high = HOST_REQ_I.wr && hit(HOST_REQ_I, OFS_GAIN_HIGH);
   assign gain_clear   = HOST_REQ_I.rd && hit(HOST_REQ_I, OFS_GAIN_RESET);

   gain_select #(.CHANNELS(GAIN_CHANNELS)) u_gain_select (
      .clk_i     (MCLK_I),
      .rst_b_i   (RST_B_I),
      .wr_low_i  (wr_gain_low),
      .wr_high_i (wr_gain_high),
      .clear_i   (gain_clear),
      .wdata_i   (HOST_REQ_I.wdata),
      .channel_i (CHANNEL_I),
      .gain_o    (GAIN_SELECT_O)
   );

   // ======================================================
   // register behaviour
   always_comb begin
      next_st = st;
      next_st.rdata = '0;
      if (HOST_REQ_I.wr && hit(HOST_REQ_I, OFS_DAC0)) begin
         if (DAC_MODE_I == DAC_SIMULTANEOUS && HOST_REQ_I.wdata == DAC_SIMUL_STROBE) begin
            next_st.dac0 = st.dac0_hold;
            next_st.dac1 = st.dac1_hold;
         end else begin
            next_st.dac0_hold = HOST_REQ_I.wdata[DAC_BITS-1:0];
            if (DAC_MODE_I == DAC_AUTOMATIC) next_st.dac0 = HOST_REQ_I.wdata[DAC_BITS-1:0];
         end
      end
      if (HOST_REQ_I.wr && hit(HOST_REQ_I, OFS_DAC1)) begin
         next_st.dac1_hold = HOST_REQ_I.wdata[DAC_BITS-1:0];
         if (DAC_MODE_I == DAC_AUTOMATIC) next_st.dac1 = HOST_REQ_I.wdata[DAC_BITS-1:0];
      end
      if (HOST_REQ_I.wr && hit(HOST_REQ_I, OFS_EEPROM)) begin
         next_st.ee_data  = HOST_REQ_I.wdata[EE_DATA_BIT];
         next_st.ee_clock = HOST_REQ_I.wdata[EE_CLOCK_BIT];
      end
      if (HOST_REQ_I.rd && hit(HOST_REQ_I, OFS_DIAG)) begin
         next_st.overflow_sticky_flag  = 1'b0;
         next_st.underflow_sticky_flag = 1'b0;
      end
      if (FIFO_I.fifo_full) next_st.overflow_sticky_flag = 1'b1;
      if (FIFO_I.fifo_empty_read) next_st.underflow_sticky_flag = 1'b1;
      next_st.irq = IRQ_ENABLE_I && FIFO_I.fifo_over_half;
      if (HOST_REQ_I.rd) begin
         case (HOST_REQ_I.addr)
            OFS_STATUS: begin
               next_st.rdata[STAT_EMPTY_BIT] = FIFO_I.fifo_empty;
               next_st.rdata[STAT_FULL_BIT]  = FIFO_I.fifo_full;
               next_st.rdata[STAT_HALF_BIT]  = FIFO_I.fifo_over_half;
               next_st.rdata[4:0]            = jumpers_s;
            end
            OFS_DIAG: begin
               next_st.rdata[DIAG_OVER_BIT]  = st.overflow_sticky_flag || FIFO_I.fifo_full;
               next_st.rdata[DIAG_UNDER_BIT] = st.underflow_sticky_flag;
            end
            OFS_EEPROM: next_st.rdata[EE_DATA_BIT] = ee_out_s;
            default: next_st.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (!RST_B_I) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // ======================================================
   // outputs
   assign HOST_RDATA_O          = st.rdata;
   assign DAC0_CODE_O           = st.dac0;
   assign DAC1_CODE_O           = st.dac1;
   assign IRQ_O                 = st.irq;
   assign EEPROM_DATA_O         = st.ee_data;
   assign EEPROM_SERIAL_CLOCK_O = st.ee_clock;

   // ======================================================
   // checks
   sequence simul_strobe_s;
      HOST_REQ_I.wr && hit(HOST_REQ_I, OFS_DAC0) && DAC_MODE_I == DAC_SIMULTANEOUS
         && HOST_REQ_I.wdata == DAC_SIMUL_STROBE;
   endsequence

   dac_simul_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      simul_strobe_s |=> DAC0_CODE_O == $past(st.dac0_hold)
         && DAC1_CODE_O == $past(st.dac1_hold)) else $error("simultaneous update failed");
   dac_auto_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      HOST_REQ_I.wr && hit(HOST_REQ_I, OFS_DAC1) && DAC_MODE_I == DAC_AUTOMATIC
         |=> DAC1_CODE_O == $past(HOST_REQ_I.wdata[11:0])) else $error("dac1 not updated");
   status_full_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      HOST_REQ_I.rd && HOST_REQ_I.addr == OFS_STATUS
         |=> HOST_RDATA_O[6] == $past(FIFO_I.fifo_full)) else $error("full bit wrong");
   status_empty_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      HOST_REQ_I.rd && HOST_REQ_I.addr == OFS_STATUS
         |=> HOST_RDATA_O[7] == $past(FIFO_I.fifo_empty)) else $error("empty bit wrong");
   over_sticky_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      FIFO_I.fifo_full ##1 (HOST_REQ_I.rd && HOST_REQ_I.addr == OFS_DIAG)
         |=> HOST_RDATA_O[0]) else $error("overflow history lost");
   under_sticky_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      FIFO_I.fifo_empty_read |=> st.underflow_sticky_flag) else $error("underflow not held");
   irq_gate_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      IRQ_O |-> $past(IRQ_ENABLE_I) && $past(FIFO_I.fifo_over_half))
      else $error("request without cause");
   ee_clock_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      HOST_REQ_I.wr && HOST_REQ_I.addr == OFS_EEPROM
         |=> EEPROM_SERIAL_CLOCK_O == $past(HOST_REQ_I.wdata[0])) else $error("clock bit wrong");

   // ======================================================
   // access sequences
   sequence status_read_s;
      HOST_REQ_I.rd && hit(HOST_REQ_I, OFS_STATUS);
   endsequence

   sequence diag_read_s;
      HOST_REQ_I.rd && hit(HOST_REQ_I, OFS_DIAG);
   endsequence

   sequence ee_write_s;
      HOST_REQ_I.wr && hit(HOST_REQ_I, OFS_EEPROM);
   endsequence

   sequence ee_read_s;
      HOST_REQ_I.rd && hit(HOST_REQ_I, OFS_EEPROM);
   endsequence

   sequence dac0_write_s;
      HOST_REQ_I.wr && hit(HOST_REQ_I, OFS_DAC0);
   endsequence

   sequence dac1_write_s;
      HOST_REQ_I.wr && hit(HOST_REQ_I, OFS_DAC1);
   endsequence

   // ======================================================
   // read data checks
   // idle read data
   rdata_idle_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      !HOST_REQ_I.rd |=> HOST_RDATA_O == 16'h0000) else $error("read data not idle");
   status_half_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      status_read_s |=> HOST_RDATA_O[5] == $past(FIFO_I.fifo_over_half))
      else $error("half bit wrong");
   status_jumper_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      status_read_s |=> HOST_RDATA_O[4:0] == $past(jumpers_s)) else $error("jumper bits wrong");
   status_high_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      status_read_s |=> HOST_RDATA_O[15:8] == 8'h00) else $error("status upper byte set");
   read_unmapped_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      HOST_REQ_I.rd && HOST_REQ_I.addr != OFS_STATUS && HOST_REQ_I.addr != OFS_DIAG
         && HOST_REQ_I.addr != OFS_EEPROM |=> HOST_RDATA_O == 16'h0000)
      else $error("unmapped read not zero");

   // ======================================================
   // sticky flag checks
   // full reads high
   diag_full_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      diag_read_s ##0 FIFO_I.fifo_full |=> HOST_RDATA_O[DIAG_OVER_BIT])
      else $error("overflow bit low while full");
   over_clear_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      diag_read_s ##0 !FIFO_I.fifo_full |=> !st.overflow_sticky_flag)
      else $error("overflow history not cleared");
   over_set_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      FIFO_I.fifo_full |=> st.overflow_sticky_flag) else $error("overflow not recorded");
   under_clear_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      diag_read_s ##0 !FIFO_I.fifo_empty_read |=> !st.underflow_sticky_flag)
      else $error("underflow history not cleared");
   under_read_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      diag_read_s |=> HOST_RDATA_O[DIAG_UNDER_BIT] == $past(st.underflow_sticky_flag))
      else $error("underflow bit wrong");

   // ======================================================
   // request checks
   // request raised
   irq_set_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      IRQ_ENABLE_I && FIFO_I.fifo_over_half |=> IRQ_O) else $error("request missing");
   irq_low_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      !IRQ_ENABLE_I |=> !IRQ_O) else $error("request while disabled");

   // ======================================================
   // serial port checks
   // data bit written
   ee_data_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      ee_write_s |=> EEPROM_DATA_O == $past(HOST_REQ_I.wdata[7]))
      else $error("serial data bit wrong");
   ee_hold_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      !(HOST_REQ_I.wr && HOST_REQ_I.addr == OFS_EEPROM)
         |=> $stable(EEPROM_DATA_O) && $stable(EEPROM_SERIAL_CLOCK_O))
      else $error("serial pins moved");
   ee_read_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      ee_read_s |=> HOST_RDATA_O[7] == $past(ee_out_s) && HOST_RDATA_O[6:0] == 7'h00
         && HOST_RDATA_O[15:8] == 8'h00) else $error("serial read wrong");

   // ======================================================
   // converter output checks
   // automatic dac0 code
   dac0_auto_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      dac0_write_s ##0 DAC_MODE_I == DAC_AUTOMATIC
         |=> DAC0_CODE_O == $past(HOST_REQ_I.wdata[11:0])) else $error("dac0 not updated");
   dac0_wait_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      dac0_write_s ##0 (DAC_MODE_I == DAC_SIMULTANEOUS
         && HOST_REQ_I.wdata != DAC_SIMUL_STROBE) |=> $stable(DAC0_CODE_O))
      else $error("dac0 moved before strobe");
   dac1_wait_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      dac1_write_s ##0 DAC_MODE_I == DAC_SIMULTANEOUS |=> $stable(DAC1_CODE_O))
      else $error("dac1 moved before strobe");
   dac_keep_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      simul_strobe_s |=> $stable(st.dac0_hold) && $stable(st.dac1_hold))
      else $error("strobe overwrote held codes");
   dac_quiet_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      !(HOST_REQ_I.wr && (HOST_REQ_I.addr == OFS_DAC0 || HOST_REQ_I.addr == OFS_DAC1))
         |=> $stable(DAC0_CODE_O) && $stable(DAC1_CODE_O)) else $error("dac moved");

   // ======================================================
   // gain reset check
   // unity gain after reset read
   gain_unity_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      gain_clear |=> ##1 GAIN_SELECT_O == 2'b00) else $error("gain not unity");
endmodule

// file: verif/host_model.sv
// host bus master model: word access and serial memory frames
module host_model
   import daq_regs_pkg::*;
#(
   parameter int EE_BUSY_CYCLES = 64
) (
   input  wire logic                clk_i,
   input  wire logic [15:0]         rdata_i,
   output daq_regs_pkg::host_req_t  req_o
);
   timeunit 1ns;
   timeprecision 100ps;

   initial req_o = '0;

   // ==========
   // word access
   // full 16-bit word
   task automatic access(input logic rd, input logic [4:0] a, input logic [15:0] d,
                         output logic [15:0] q);
      req_o <= '{rd: rd, wr: ~rd, addr: a, wdata: d};
      @(posedge clk_i);
      req_o <= '0;
      @(negedge clk_i);
      q = rdata_i;
      @(posedge clk_i);
   endtask

   // ==========
   // memory write frame
   task automatic ee_write(input logic [5:0] a, input logic [15:0] d);
      logic [24:0] bits;
      logic [15:0] q;
      bits = {1'b1, 2'b01, a, d};
      for (int i = 24; i >= 0; i--) begin
         access(1'b0, OFS_EEPROM, {8'h00, bits[i], 6'h00, 1'b1}, q);
      end
      access(1'b0, OFS_EEPROM, 16'h0000, q);
      repeat (EE_BUSY_CYCLES) @(posedge clk_i);
   endtask
endmodule

// file: verif/tb_adc_gain_dac_status_regs.sv
// self-checking bench for the acquisition register group
module tb_adc_gain_dac_status_regs;
   timeunit 1ns;
   timeprecision 100ps;
   import daq_regs_pkg::*;

   typedef struct packed {
      fifo_state_t f;
      jumpers_t    j;
      logic        en;
      logic [15:0] stat;
      logic        irq;
   } row_t;

   logic        mclk = 1'b0;
   logic        rst_b = 1'b0;
   host_req_t   req;
   logic [15:0] rdata;
   logic [15:0] q;
   fifo_state_t fifo = '0;
   jumpers_t    jmp = '0;
   logic        irq_en = 1'b0;
   dac_mode_t   mode = DAC_AUTOMATIC;
   logic [3:0]  chan = 4'h0;
   logic [1:0]  gain;
   logic [11:0] dac0;
   logic [11:0] dac1;
   logic        irq;
   logic        ee_data;
   logic        ee_clk;
   logic        ee_out = 1'b0;
   int          fail_count = 0;
   int          tests_run = 0;
   row_t        rows [4] = '{
      '{4'h8, 5'h00, 1'b0, 16'h0080, 1'b0},
      '{4'h4, 5'h15, 1'b1, 16'h0055, 1'b0},
      '{4'h2, 5'h0a, 1'b1, 16'h002a, 1'b1},
      '{4'h2, 5'h1f, 1'b0, 16'h003f, 1'b0}};

   // ==========
   // design and host
   daq_regs daq_regs_inst (
      .MCLK_I(mclk), .RST_B_I(rst_b), .HOST_REQ_I(req), .HOST_RDATA_O(rdata),
      .FIFO_I(fifo), .JUMPERS_I(jmp), .IRQ_ENABLE_I(irq_en), .DAC_MODE_I(mode),
      .CHANNEL_I(chan), .GAIN_SELECT_O(gain), .DAC0_CODE_O(dac0),
      .DAC1_CODE_O(dac1), .IRQ_O(irq), .EEPROM_DATA_O(ee_data),
      .EEPROM_SERIAL_CLOCK_O(ee_clk), .EEPROM_SERIAL_OUT_I(ee_out));

   host_model #(.EE_BUSY_CYCLES(64)) host_model_inst (
      .clk_i(mclk), .rdata_i(rdata), .req_o(req));

   always #2 mclk = ~mclk;

   // ==========
   // helpers
   task automatic chk(input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         fail_count++;
         $display("Error at %0t: expected %h got %h", $time, e, g);
      end
   endtask

   task automatic rd(input logic [4:0] a);
      host_model_inst.access(1'b1, a, 16'h0000, q);
   endtask

   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      host_model_inst.access(1'b0, a, d, q);
   endtask

   task automatic gains(input logic [31:0] codes);
      for (int c = 0; c < 16; c++) begin
         chan <= c[3:0];
         repeat (2) @(posedge mclk);
         chk({14'h0, codes[2*c +: 2]}, {14'h0, gain});
      end
   endtask

   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge mclk);
      fail_count++;
      close_out();
   end

   // ==========
   // main sequence
   initial begin
      repeat (16) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
      chk(16'h0000, {dac0, gain, irq, ee_data});
      chk(16'h0000, {4'h0, dac1});
      foreach (rows[i]) begin
         fifo <= rows[i].f;
         jmp <= rows[i].j;
         irq_en <= rows[i].en;
         repeat (4) @(posedge mclk);
         rd(OFS_STATUS);
         chk(rows[i].stat, q);
         chk({15'h0, rows[i].irq}, {15'h0, irq});
      end
      fifo <= '0;
      @(posedge mclk);
      rd(OFS_DIAG);
      chk(16'h0001, q);
      rd(OFS_DIAG);
      chk(16'h0000, q);
      fifo.fifo_empty_read <= 1'b1;
      @(posedge mclk);
      fifo.fifo_empty_read <= 1'b0;
      rd(OFS_DIAG);
      chk(16'h0002, q);
      rd(OFS_DIAG);
      chk(16'h0000, q);
      wr(OFS_GAIN_LOW, 16'he4e4);
      wr(OFS_GAIN_HIGH, 16'h1b1b);
      gains({16'h1b1b, 16'he4e4});
      rd(OFS_GAIN_RESET);
      gains(32'h0000_0000);
      wr(OFS_DAC0, 16'h0fff);
      chk(16'h0fff, {4'h0, dac0});
      wr(OFS_DAC1, 16'h0123);
      chk(16'h0123, {4'h0, dac1});
      mode <= DAC_SIMULTANEOUS;
      wr(OFS_DAC0, 16'h0abc);
      wr(OFS_DAC1, 16'h0456);
      chk(16'h0fff, {4'h0, dac0});
      chk(16'h0123, {4'h0, dac1});
      wr(OFS_DAC0, DAC_SIMUL_STROBE);
      chk(16'h0abc, {4'h0, dac0});
      chk(16'h0456, {4'h0, dac1});
      mode <= DAC_AUTOMATIC;
      rd(5'h03);
      chk(16'h0000, q);
      wr(OFS_EEPROM, 16'h0081);
      chk(16'h0003, {14'h0, ee_data, ee_clk});
      host_model_inst.ee_write(6'h05, 16'haa55);
      chk(16'h0000, {14'h0, ee_data, ee_clk});
      ee_out <= 1'b1;
      repeat (3) @(posedge mclk);
      rd(OFS_EEPROM);
      chk(16'h0001, {15'h0, q[7]});
      ee_out <= 1'b0;
      repeat (3) @(posedge mclk);
      rd(OFS_EEPROM);
      chk(16'h0000, {15'h0, q[7]});
      close_out();
   end
endmodule
